// file: pad_pull_pkg.sv
package pad_pull_pkg;

   localparam int unsigned ADDR_DECODE_WIDTH = 8;
   localparam int unsigned DATA_WIDTH        = 32;

   localparam logic [7:0] BUS_CONTROL_OFFSET = 8'h18;
   localparam logic [7:0] ADDRESS_PINS_OFFSET = 8'h1c;
   localparam logic [7:0] INTERRUPT_PINS_OFFSET = 8'h20;

   localparam int unsigned BUS_CONTROL_FIELDS    = 6;
   localparam int unsigned ADDRESS_PINS_FIELDS   = 8;
   localparam int unsigned INTERRUPT_PINS_FIELDS = 7;

   localparam int unsigned BUS_CONTROL_WIDTH    = 12;
   localparam int unsigned ADDRESS_PINS_WIDTH   = 16;
   localparam int unsigned INTERRUPT_PINS_WIDTH = 14;

   localparam logic [11:0] BUS_CONTROL_RESET    = 12'h555;
   localparam logic [15:0] ADDRESS_PINS_RESET   = 16'h0000;
   localparam logic [13:0] INTERRUPT_PINS_RESET = 14'h095a;

   // meaning of selector code 11, two bits per field
   localparam logic [1:0] PULL_KIND_DOWN = 2'h0;
   localparam logic [1:0] PULL_KIND_UP   = 2'h1;
   localparam logic [1:0] PULL_KIND_NONE = 2'h2;

   localparam logic [1:0] SEL_DOWN = 2'h0;
   localparam logic [1:0] SEL_UP   = 2'h1;
   localparam logic [1:0] SEL_NONE = 2'h2;
   localparam logic [1:0] SEL_ALT  = 2'h3;

   localparam logic [11:0] BUS_CONTROL_ALT_MAP    = 12'h555;
   localparam logic [15:0] ADDRESS_PINS_ALT_MAP   = 16'h0000;
   localparam logic [13:0] INTERRUPT_PINS_ALT_MAP = 14'h095a;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   typedef enum logic [1:0]
   {
      PHASE_IDLE  = 2'b00,
      PHASE_WRITE = 2'b01,
      PHASE_READ  = 2'b10
   } phase_type;

   // returns {pull_up, pull_down}; never both high
   function automatic logic [1:0] decode_pull(input logic [1:0] sel,
                                              input logic [1:0] alt);
      logic [1:0] kind;
      kind = (sel == SEL_ALT) ? alt : sel;
      case (kind)
         PULL_KIND_DOWN: decode_pull = 2'b01;
         PULL_KIND_UP:   decode_pull = 2'b10;
         default:        decode_pull = 2'b00;
      endcase
   endfunction

endpackage

// file: pull_bank_decoder.sv
module pull_bank_decoder
#(
   parameter int unsigned       FIELDS  = 6,
   parameter logic [2*FIELDS-1:0] ALT_MAP = '0
)
(
   input  wire logic [2*FIELDS-1:0] select_i,
   output logic      [FIELDS-1:0]   pull_up_o,
   output logic      [FIELDS-1:0]   pull_down_o
);

   always_comb
   begin
      for (int i = 0; i < FIELDS; i++)
      begin
         // per-field code 11 meaning differs by pin
         {pull_up_o[i], pull_down_o[i]} = pad_pull_pkg::decode_pull(
            select_i[2*i +: 2], ALT_MAP[2*i +: 2]);
      end
   end

endmodule // pull_bank_decoder

// file: pad_pull_resistor_select.sv
// The implementer's own choice: the AHB-Lite interface to the registers.
module pad_pull_resistor_select
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic      [31:0] hrdata_o,
   output logic      [5:0]  bus_control_pull_up_o,
   output logic      [5:0]  bus_control_pull_down_o,
   output logic      [7:0]  address_pins_pull_up_o,
   output logic      [7:0]  address_pins_pull_down_o,
   output logic      [6:0]  interrupt_pins_pull_up_o,
   output logic      [6:0]  interrupt_pins_pull_down_o
);

   typedef struct packed
   {
      pad_pull_pkg::phase_type phase;
      logic [7:0]              addr;
      logic [11:0]             bus_control_pins_pull_select;
      logic [15:0]             address_pins_pull_select;
      logic [13:0]             interrupt_pins_pull_select;
      logic [31:0]             rdata;
   } state_type;

   localparam state_type STATE_RESET = '{
      phase:                        pad_pull_pkg::PHASE_IDLE,
      addr:                         8'h00,
      bus_control_pins_pull_select: pad_pull_pkg::BUS_CONTROL_RESET,
      address_pins_pull_select:     pad_pull_pkg::ADDRESS_PINS_RESET,
      interrupt_pins_pull_select:   pad_pull_pkg::INTERRUPT_PINS_RESET,
      rdata:                        32'h0000_0000
   };

   state_type s_q;
   state_type s_d;

   // reserved upper bits are not stored, so they always read zero
   function automatic logic [31:0] read_word(input state_type s,
                                             input logic [7:0] a);
      case (a)
         pad_pull_pkg::BUS_CONTROL_OFFSET:
            read_word = {20'h0_0000, s.bus_control_pins_pull_select};
         pad_pull_pkg::ADDRESS_PINS_OFFSET:
            read_word = {16'h0000, s.address_pins_pull_select};
         pad_pull_pkg::INTERRUPT_PINS_OFFSET:
            read_word = {18'h0_0000, s.interrupt_pins_pull_select};
         default:
            read_word = 32'h0000_0000;
      endcase
   endfunction

   always_comb
   begin
      s_d = s_q;
      // data phase of a write: commit the field bits only
      case (s_q.phase)
         pad_pull_pkg::PHASE_WRITE:
         begin
            case (s_q.addr)
               pad_pull_pkg::BUS_CONTROL_OFFSET:
                  s_d.bus_control_pins_pull_select = hwdata_i[11:0];
               pad_pull_pkg::ADDRESS_PINS_OFFSET:
                  s_d.address_pins_pull_select = hwdata_i[15:0];
               pad_pull_pkg::INTERRUPT_PINS_OFFSET:
                  s_d.interrupt_pins_pull_select = hwdata_i[13:0];
               default:
                  s_d.rdata = s_q.rdata;
            endcase
         end
         default:
            s_d.rdata = s_q.rdata;
      endcase
      // address phase; read data taken from the updated copy so a read
      // right behind a write to the same register sees the new value
      if (hsel_i && hready_i && (htrans_i == pad_pull_pkg::HTRANS_NONSEQ
                                 || htrans_i == 2'h3))
      begin
         s_d.addr = haddr_i[7:0];
         if (hwrite_i)
         begin
            s_d.phase = pad_pull_pkg::PHASE_WRITE;
         end
         else
         begin
            s_d.phase = pad_pull_pkg::PHASE_READ;
            s_d.rdata = read_word(s_d, haddr_i[7:0]);
         end
      end
      else if (hready_i)
      begin
         s_d.phase = pad_pull_pkg::PHASE_IDLE;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         s_q <= STATE_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // zero wait states; hsize is not checked, every write updates the word
   assign hreadyout_o = 1'b1;
   assign hresp_o     = pad_pull_pkg::HRESP_OKAY;
   assign hrdata_o    = s_q.rdata;

   pull_bank_decoder
   #(
      .FIELDS  (pad_pull_pkg::BUS_CONTROL_FIELDS),
      .ALT_MAP (pad_pull_pkg::BUS_CONTROL_ALT_MAP)
   )
   bus_control_decoder
   (
      .select_i    (s_q.bus_control_pins_pull_select),
      .pull_up_o   (bus_control_pull_up_o),
      .pull_down_o (bus_control_pull_down_o)
   );

   pull_bank_decoder
   #(
      .FIELDS  (pad_pull_pkg::ADDRESS_PINS_FIELDS),
      .ALT_MAP (pad_pull_pkg::ADDRESS_PINS_ALT_MAP)
   )
   address_pins_decoder
   (
      .select_i    (s_q.address_pins_pull_select),
      .pull_up_o   (address_pins_pull_up_o),
      .pull_down_o (address_pins_pull_down_o)
   );

   // alt map: irq6 down, irq5 none, irq4..2 up, irq1..0 none
   pull_bank_decoder
   #(
      .FIELDS  (pad_pull_pkg::INTERRUPT_PINS_FIELDS),
      .ALT_MAP (pad_pull_pkg::INTERRUPT_PINS_ALT_MAP)
   )
   interrupt_pins_decoder
   (
      .select_i    (s_q.interrupt_pins_pull_select),
      .pull_up_o   (interrupt_pins_pull_up_o),
      .pull_down_o (interrupt_pins_pull_down_o)
   );

endmodule // pad_pull_resistor_select

// file: pad_pull_resistor_select_asserts.sv
module pad_pull_resistor_select_asserts
(
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   input wire logic        hsel_i,
   input wire logic [1:0]  htrans_i,
   input wire logic        hwrite_i,
   input wire logic [31:0] hrdata_o,
   input wire logic [5:0]  bus_control_pull_up_o,
   input wire logic [5:0]  bus_control_pull_down_o,
   input wire logic [7:0]  address_pins_pull_up_o,
   input wire logic [7:0]  address_pins_pull_down_o,
   input wire logic [6:0]  interrupt_pins_pull_up_o,
   input wire logic [6:0]  interrupt_pins_pull_down_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   a_bc_reset: assert property ($fell(rst_i) |->
      bus_control_pull_up_o == 6'h3f && bus_control_pull_down_o == 6'h00)
      else $error("bus-control pulls wrong after reset");
   a_addr_reset: assert property ($fell(rst_i) |->
      address_pins_pull_down_o == 8'hff && address_pins_pull_up_o == 8'h00)
      else $error("address pulls wrong after reset");
   a_irq_reset: assert property ($fell(rst_i) |->
      interrupt_pins_pull_up_o == 7'h1c && interrupt_pins_pull_down_o == 7'h40)
      else $error("interrupt pulls wrong after reset");
   a_rdata_reset: assert property ($fell(rst_i) |-> hrdata_o == 32'h0)
      else $error("read data not zero after reset");
   a_bc_excl: assert property ((bus_control_pull_up_o
      & bus_control_pull_down_o) == 6'h00) else $error("bus-control both on");
   a_addr_excl: assert property ((address_pins_pull_up_o
      & address_pins_pull_down_o) == 8'h00) else $error("address both on");
   a_irq_excl: assert property ((interrupt_pins_pull_up_o
      & interrupt_pins_pull_down_o) == 7'h00) else $error("interrupt both on");
   // bus-control pull-ups, address pull-downs and interrupt pull-ups must only move two edges after a write address phase or one edge after reset
   a_no_stray: assert property ($changed({bus_control_pull_up_o,
      address_pins_pull_down_o, interrupt_pins_pull_up_o}) |->
      $past(hsel_i && hwrite_i && htrans_i[1], 2) || $past(rst_i))
      else $error("pull outputs moved without a write");
endmodule // pad_pull_resistor_select_asserts

// file: pad_pull_resistor_select_tb.sv
module pad_pull_resistor_select_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk_i = 1'b0, rst_i = 1'b1, hsel_i = 1'b0;
   logic        hwrite_i = 1'b0, hreadyout_o, hresp_o;
   logic [1:0]  htrans_i = 2'h0;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
   logic [5:0]  bc_up, bc_dn;
   logic [7:0]  ad_up, ad_dn;
   logic [6:0]  ir_up, ir_dn;
   int          n_errors = 0, checked = 0;
   pad_pull_resistor_select dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
      .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
      .hrdata_o(hrdata_o), .bus_control_pull_up_o(bc_up),
      .bus_control_pull_down_o(bc_dn), .address_pins_pull_up_o(ad_up),
      .address_pins_pull_down_o(ad_dn), .interrupt_pins_pull_up_o(ir_up),
      .interrupt_pins_pull_down_o(ir_dn));
   initial forever #2 ref_clk_i = ~ref_clk_i;
   task results;
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // hready is constant high, but never assume it
   task wait_rdy;
      int i;
      for (i = 0; i < 16; i++)
      begin
         @(posedge ref_clk_i);
         if (hreadyout_o === 1'b1) break;
      end
      if (i == 16)
      begin
         n_errors++;
         results();
      end
   endtask
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel_i <= 1'b1;
      haddr_i <= {24'h0, a};
      htrans_i <= pad_pull_pkg::HTRANS_NONSEQ;
      hwrite_i <= wr;
      wait_rdy();
      htrans_i <= 2'h0;
      hwdata_i <= d;
      wait_rdy();
      rd = hrdata_o;
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, hresp_o}, 32'h0);
   endtask
   task do_reset;
      rst_i <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task reset_values;
      rd_chk(8'h18, 32'h555);
      rd_chk(8'h1c, 32'h0);
      rd_chk(8'h20, 32'h95a);
   endtask
   task decode_all;
      logic [31:0] p;
      for (int c = 0; c < 4; c++)
      begin
         p = {16{c[1:0]}};
         xfer(1'b1, 8'h18, p & 32'hfff);
         xfer(1'b1, 8'h1c, p & 32'hffff);
         xfer(1'b1, 8'h20, p & 32'h3fff);
         rd_chk(8'h18, p & 32'hfff);
         rd_chk(8'h1c, p & 32'hffff);
         rd_chk(8'h20, p & 32'h3fff);
         @(posedge ref_clk_i);
         #1;
         chk({bc_up, bc_dn},
            {(c % 2) ? 6'h3f : 6'h0, c ? 6'h0 : 6'h3f});
         chk({ad_up, ad_dn}, {(c == 1) ? 8'hff : 8'h0,
            (c == 0 || c == 3) ? 8'hff : 8'h0});
         chk({ir_up, ir_dn}, (c == 3) ? 14'he40 :
            {(c == 1) ? 7'h7f : 7'h0, c ? 7'h0 : 7'h7f});
      end
   endtask
   task unmapped;
      xfer(1'b1, 8'h24, 32'h3);
      rd_chk(8'h24, 32'h0);
      rd_chk(8'h18, 32'hfff);
   endtask
   initial
   begin
      do_reset();
      reset_values();
      decode_all();
      unmapped();
      do_reset();
      reset_values();
      results();
   end
endmodule // pad_pull_resistor_select_tb
bind pad_pull_resistor_select pad_pull_resistor_select_asserts chk_i (.*);
